// [core/mnp_pkg.sv]
// Shared constants for the nibble port between the MAC and the PHY
package mnp_pkg;

  localparam int unsigned NIB_W       = 4;        // Nibble width on both data paths
  localparam int unsigned BYTE_W      = 8;        // User-side byte width
  localparam int unsigned SYNC_STAGES = 2;        // Flops before any logic reads a pin
  localparam int unsigned LO_NIB_POS  = 0;        // Low nibble position, sent and received first
  localparam int unsigned HI_NIB_POS  = 4;        // High nibble position, second on the wire

  // Values after reset
  localparam logic [3:0] TXD_RST      = 4'h0;
  localparam logic       TX_VALID_RST = 1'b0;
  localparam logic       HALF_DPX_RST = 1'b0;     // Full duplex until the strap is seen

  // Transmit nibble sequencer
  typedef enum logic [1:0] {
    MNP_TX_IDLE,
    MNP_TX_HIGH,
    MNP_TX_NEXT
  } mnp_tx_state_e;

endpackage

// [core/mnp_sync.sv]
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module mnp_sync
  import mnp_pkg::*;
#(
  parameter int unsigned WIDTH = 1
)(
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// [core/mnp_top.sv]
// Nibble port between the MAC core and an external Ethernet PHY
`timescale 1ns/1ps
module mnp_top
  import mnp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  // PHY side
  input  wire logic              tx_nibble_clock,
  output logic                   tx_nibble_valid,
  output logic [NIB_W-1:0]       txd,
  input  wire logic              rx_nibble_clock,
  input  wire logic              rx_nibble_valid,
  input  wire logic [NIB_W-1:0]  rxd,
  input  wire logic              col,
  input  wire logic              crs,
  input  wire logic              duplex_strap_n,
  // MAC side, transmit bytes
  input  wire logic [BYTE_W-1:0] tx_byte,
  input  wire logic              tx_byte_last,
  input  wire logic              tx_byte_valid,
  output logic                   tx_byte_ready,
  output logic                   tx_underrun,
  // MAC side, receive bytes
  output logic [BYTE_W-1:0]      rx_byte,
  output logic                   rx_byte_valid,
  output logic                   rx_frame_end,
  output logic                   rx_odd_nibble,
  // MAC side, medium status
  output logic                   collision,
  output logic                   carrier,
  output logic                   half_duplex
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic             txc_s;
  logic             rxc_s;
  logic             rx_nibble_valid_s;
  logic [NIB_W-1:0] rxd_s;
  logic             col_s;
  logic             crs_s;
  logic             strap_n_s;
  // Link clocks are sampled, not used as clocks: one core domain only
  mnp_sync #(.WIDTH(1)) u_sync_txc (
    .clk      (clk),
    .rstn     (rstn),
    .async_in (tx_nibble_clock),
    .sync_out (txc_s)
  );

  // Receive clock, valid and data share stages so they stay aligned
  mnp_sync #(.WIDTH(NIB_W + 2)) u_sync_rx (
    .clk      (clk),
    .rstn     (rstn),
    .async_in ({rx_nibble_clock, rx_nibble_valid, rxd}),
    .sync_out ({rxc_s, rx_nibble_valid_s, rxd_s})
  );

  mnp_sync #(.WIDTH(3)) u_sync_misc (
    .clk      (clk),
    .rstn     (rstn),
    .async_in ({col, crs, duplex_strap_n}),
    .sync_out ({col_s, crs_s, strap_n_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Link clock edge detection
  logic txc_prev_q;
  logic rxc_prev_q;
  logic tx_edge;
  logic rx_edge;
  // Previous sampled level of each link clock
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      txc_prev_q <= 1'b0;
      rxc_prev_q <= 1'b0;
    end
    else
    begin
      txc_prev_q <= txc_s;
      rxc_prev_q <= rxc_s;
    end
  end

  assign tx_edge = txc_s & ~txc_prev_q;
  assign rx_edge = rxc_s & ~rxc_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Duplex strap and medium status
  // Strap followed after reset release; the reset itself loads HALF_DPX_RST (full duplex)
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      half_duplex <= HALF_DPX_RST;
      collision   <= 1'b0;
      carrier     <= 1'b0;
    end
    else
    begin
      half_duplex <= strap_n_s;
      collision   <= col_s & half_duplex;
      carrier     <= crs_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit byte holding register
  logic [BYTE_W-1:0] hold_q;
  logic              hold_last_q;
  logic              hold_full_q;
  logic              hold_full_d;
  logic              tx_accept;
  logic              tx_take;
  mnp_tx_state_e     tx_state_q;
  logic [BYTE_W-1:0] cur_q;
  logic              cur_last_q;
  // A byte leaves the holder only when its low nibble goes out
  assign tx_accept = tx_byte_valid & tx_byte_ready;
  assign tx_take   = tx_edge & hold_full_q &
                     ((tx_state_q == MNP_TX_IDLE) | ((tx_state_q == MNP_TX_NEXT) & ~cur_last_q));

  always_comb
  begin
    hold_full_d = hold_full_q;
    if (tx_accept)
      hold_full_d = 1'b1;
    else if (tx_take)
      hold_full_d = 1'b0;
  end

  // One byte of buffering; ready is registered so it stalls the MAC early
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      hold_q        <= '0;
      hold_last_q   <= 1'b0;
      hold_full_q   <= 1'b0;
      tx_byte_ready <= 1'b0;
    end
    else
    begin
      hold_full_q   <= hold_full_d;
      tx_byte_ready <= ~hold_full_d;
      if (tx_accept)
      begin
        hold_q      <= tx_byte;
        hold_last_q <= tx_byte_last;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit nibble sequencer, changes only on a transmit clock rise
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      tx_state_q      <= MNP_TX_IDLE;
      tx_nibble_valid <= TX_VALID_RST;
      txd             <= TXD_RST;
      cur_q           <= '0;
      cur_last_q      <= 1'b0;
      tx_underrun     <= 1'b0;
    end
    else
    begin
      tx_underrun <= 1'b0;
      if (tx_edge)
      begin
        case (tx_state_q)
          MNP_TX_IDLE:
          begin
            if (hold_full_q)
            begin
              txd             <= hold_q[LO_NIB_POS +: NIB_W];
              tx_nibble_valid <= 1'b1;
              cur_q           <= hold_q;
              cur_last_q      <= hold_last_q;
              tx_state_q      <= MNP_TX_HIGH;
            end
            else
            begin
              tx_nibble_valid <= 1'b0;
              txd             <= TXD_RST;
            end
          end
          MNP_TX_HIGH:
          begin
            txd        <= cur_q[HI_NIB_POS +: NIB_W];
            tx_state_q <= MNP_TX_NEXT;
          end
          MNP_TX_NEXT:
          begin
            if (cur_last_q)
            begin
              // Last nibble has been clocked out; valid falls now
              tx_nibble_valid <= 1'b0;
              txd             <= TXD_RST;
              tx_state_q      <= MNP_TX_IDLE;
            end
            else if (hold_full_q)
            begin
              txd        <= hold_q[LO_NIB_POS +: NIB_W];
              cur_q      <= hold_q;
              cur_last_q <= hold_last_q;
              tx_state_q <= MNP_TX_HIGH;
            end
            else
            begin
              // MAC ran dry mid-frame: frame is cut short, not stretched
              tx_nibble_valid <= 1'b0;
              txd             <= TXD_RST;
              tx_underrun     <= 1'b1;
              tx_state_q      <= MNP_TX_IDLE;
            end
          end
          default:
          begin
            tx_nibble_valid <= 1'b0;
            txd             <= TXD_RST;
            tx_state_q      <= MNP_TX_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive nibble assembly, sampled on a receive clock rise
  logic [NIB_W-1:0] rx_low_q;
  logic             rx_have_low_q;
  logic             rx_in_frame_q;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rx_low_q      <= '0;
      rx_have_low_q <= 1'b0;
      rx_in_frame_q <= 1'b0;
      rx_byte       <= '0;
      rx_byte_valid <= 1'b0;
      rx_frame_end  <= 1'b0;
      rx_odd_nibble <= 1'b0;
    end
    else
    begin
      rx_byte_valid <= 1'b0;
      rx_frame_end  <= 1'b0;
      rx_odd_nibble <= 1'b0;
      if (rx_edge)
      begin
        rx_in_frame_q <= rx_nibble_valid_s;
        if (rx_nibble_valid_s)
        begin
          if (rx_have_low_q)
          begin
            rx_byte       <= {rxd_s, rx_low_q};
            rx_byte_valid <= 1'b1;
            rx_have_low_q <= 1'b0;
          end
          else
          begin
            rx_low_q      <= rxd_s;
            rx_have_low_q <= 1'b1;
          end
        end
        else if (rx_in_frame_q)
        begin
          // Frame ended; a dangling nibble is dropped and reported
          rx_frame_end  <= 1'b1;
          rx_odd_nibble <= rx_have_low_q;
          rx_have_low_q <= 1'b0;
        end
      end
    end
  end

endmodule

// [testbench/mnp_sva.sv]
// Pin-level timing checks for the nibble port
`timescale 1ns/1ps
module mnp_sva
  import mnp_pkg::*;
(
  input wire logic             clk,
  input wire logic             rstn,
  input wire logic             tx_nibble_clock,
  input wire logic             tx_nibble_valid,
  input wire logic [NIB_W-1:0] txd,
  input wire logic             tx_underrun,
  input wire logic             rx_nibble_clock,
  input wire logic             col,
  input wire logic             crs,
  input wire logic             duplex_strap_n,
  input wire logic             rx_byte_valid,
  input wire logic             rx_frame_end,
  input wire logic             rx_odd_nibble,
  input wire logic             collision,
  input wire logic             carrier,
  input wire logic             half_duplex
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  // Link pins move only just after a sampled clock rise
  a_txd_idle: assert property (!tx_nibble_valid |-> txd == TXD_RST)
    else $error("txd not zero between frames");
  a_txd_step: assert property (($changed(txd) || $changed(tx_nibble_valid)) |-> $past(tx_nibble_clock, 2))
    else $error("tx pins moved away from a clock rise");
  a_rx_on_rise: assert property (rx_byte_valid |-> $past(rx_nibble_clock, 2))
    else $error("rx byte not tied to a clock rise");
  a_underrun_drop: assert property (tx_underrun |-> !tx_nibble_valid && $past(tx_nibble_valid))
    else $error("underrun pulse without valid falling");
  a_odd_end: assert property (rx_odd_nibble |-> rx_frame_end)
    else $error("odd nibble flag outside frame end");
  // Status levels, after five stable samples the synchroniser has settled
  a_col_ignored: assert property ((!duplex_strap_n) [*5] |=> !collision)
    else $error("collision seen in full duplex");
  a_col_seen: assert property ((col && duplex_strap_n) [*5] |=> collision)
    else $error("collision missed in half duplex");
  a_strap_half: assert property (duplex_strap_n [*5] |=> half_duplex)
    else $error("half duplex not taken from strap");
  a_crs_synced: assert property ($rose(carrier) |-> $past(crs, 3))
    else $error("carrier rose without synchroniser delay");
endmodule

// [testbench/mnp_phy_model.sv]
// PHY model: free-running link clocks, receive driver, transmit capture
`timescale 1ns/1ps
module mnp_phy_model
  import mnp_pkg::*;
(
  output logic                  tx_nibble_clock,
  output logic                  rx_nibble_clock,
  output logic                  rx_nibble_valid,
  output logic      [NIB_W-1:0] rxd,
  input  wire logic             tx_nibble_valid,
  input  wire logic [NIB_W-1:0] txd
);
  logic [NIB_W:0]   rx_q[$];
  logic [NIB_W-1:0] tx_q[$];
  logic [NIB_W:0]   ent;
  int               tx_frames = 0;
  logic             tx_prev = 1'b0;
  ////////////////////////////////////////
  // Clocks run free, phases unrelated to the core clock
  initial
  begin
    tx_nibble_clock = 1'b0;
    #1.3;
    forever #32 tx_nibble_clock = ~tx_nibble_clock;
  end
  initial
  begin
    rx_nibble_clock = 1'b0;
    rx_nibble_valid = 1'b0;
    rxd = 4'h5;
    #7.1;
    forever #32 rx_nibble_clock = ~rx_nibble_clock;
  end
  // Change on the fall so data is settled at the rise; idle data toggles
  always @(negedge rx_nibble_clock)
  begin
    ent = (rx_q.size() > 0) ? rx_q.pop_front() : 5'h00;
    rx_nibble_valid <= ent[NIB_W];
    rxd <= ent[NIB_W] ? ent[NIB_W-1:0] : ~rxd;
  end
  // Capture nibbles and count frames as the PHY would
  always @(posedge tx_nibble_clock)
  begin
    if (tx_nibble_valid)
      tx_q.push_back(txd);
    if (tx_nibble_valid && !tx_prev)
      tx_frames++;
    tx_prev = tx_nibble_valid;
  end
endmodule

// [testbench/mnp_top_tb.sv]
// Self-checking bench for the nibble port
`timescale 1ns/1ps
module mnp_top_tb
  import mnp_pkg::*;
;
  logic              clk, rstn, col, crs, duplex_strap_n, tx_byte_last, tx_byte_valid;
  logic [BYTE_W-1:0] tx_byte, rx_byte;
  logic [NIB_W-1:0]  txd, rxd, nb;
  logic              tx_nibble_clock, rx_nibble_clock, rx_nibble_valid, tx_nibble_valid;
  logic              tx_byte_ready, tx_underrun, rx_byte_valid, rx_frame_end, rx_odd_nibble;
  logic              collision, carrier, half_duplex;
  logic [31:0]       seed = 32'd87;
  logic [7:0]        exp_tx[$], exp_rx[$], got_rx[$], exp_odd[$], got_odd[$];
  int                error_cnt = 0, n_compared = 0, cyc = 0, exp_frames = 0;
  int                sizes[3] = '{4, 3, 1};

  mnp_top dut (.clk, .rstn, .tx_nibble_clock, .tx_nibble_valid, .txd, .rx_nibble_clock, .rx_nibble_valid,
    .rxd, .col, .crs, .duplex_strap_n, .tx_byte, .tx_byte_last, .tx_byte_valid, .tx_byte_ready, .tx_underrun,
    .rx_byte, .rx_byte_valid, .rx_frame_end, .rx_odd_nibble, .collision, .carrier, .half_duplex);
  mnp_phy_model phy (.tx_nibble_clock, .rx_nibble_clock, .rx_nibble_valid, .rxd, .tx_nibble_valid, .txd);
  ////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("errors %0d compares %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Bytes held until taken; idle wait also watches for the cut pulse
  task automatic send_frame(int n, bit cut);
    logic [7:0] b;
    int         low, k;
    logic       ur;
    for (int i = 0; i < n; i++)
    begin
      b = 8'(xs());
      exp_tx.push_back(b[3:0]);
      exp_tx.push_back(b[7:4]);
      tx_byte <= b;
      tx_byte_last <= (i == n - 1) && !cut;
      tx_byte_valid <= 1'b1;
      do @(negedge clk); while (tx_byte_ready !== 1'b1);
      @(posedge clk);
    end
    tx_byte_valid <= 1'b0;
    exp_frames++;
    low = 0;
    k = 0;
    ur = 1'b0;
    while (low < 24 && k < 600)
    begin
      @(negedge clk);
      k++;
      low = (tx_nibble_valid === 1'b0) ? low + 1 : 0;
      ur |= (tx_underrun === 1'b1);
    end
    chk("tx_underrun", cut, ur);
    @(posedge clk);
  endtask
  ////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Hang guard and receive monitor
  always @(posedge clk)
  begin
    cyc++;
    if (rx_byte_valid === 1'b1)
      got_rx.push_back(rx_byte);
    if (rx_frame_end === 1'b1)
      got_odd.push_back(8'(rx_odd_nibble));
    if (cyc == 20000)
    begin
      error_cnt++;
      close_out();
    end
  end
  initial
  begin
    {rstn, col, crs, duplex_strap_n, tx_byte_last, tx_byte_valid, tx_byte} = '0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("ready in reset", 0, tx_byte_ready);
    chk("valid in reset", 0, tx_nibble_valid);
    @(posedge clk);
    rstn <= 1'b1;
    // Every strap, collision and carrier combination
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      duplex_strap_n <= i[0];
      col <= i[1];
      crs <= i[2];
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk("half_duplex", i[0], half_duplex);
      chk("collision", i[0] & i[1], collision);
      chk("carrier", i[2], carrier);
    end
    @(posedge clk);
    send_frame(3, 0);
    send_frame(4, 0);
    send_frame(1, 1);
    chk("tx frames", exp_frames, phy.tx_frames);
    chk("tx nibbles", exp_tx.size(), phy.tx_q.size());
    foreach (exp_tx[i])
      chk("txd", exp_tx[i], phy.tx_q[i]);
    // Even, odd and lone-nibble frames with an idle nibble between
    foreach (sizes[f])
    begin
      for (int i = 0; i < sizes[f]; i++)
      begin
        phy.rx_q.push_back({1'b1, 4'(xs())});
        nb = phy.rx_q[$][3:0];
        if (i % 2 == 1)
          exp_rx.push_back({nb, phy.rx_q[$ - 1][3:0]});
      end
      phy.rx_q.push_back(5'h00);
      exp_odd.push_back(8'(sizes[f] % 2));
    end
    for (int k = 0; k < 1000 && phy.rx_q.size() > 0; k++)
      @(posedge clk);
    repeat (40) @(posedge clk);
    chk("rx bytes", exp_rx.size(), got_rx.size());
    chk("rx ends", exp_odd.size(), got_odd.size());
    foreach (exp_rx[i])
      chk("rx_byte", exp_rx[i], got_rx[i]);
    foreach (exp_odd[i])
      chk("rx_odd_nibble", exp_odd[i], got_odd[i]);
    close_out();
  end
endmodule

bind mnp_top mnp_sva chk (.clk, .rstn, .tx_nibble_clock, .tx_nibble_valid, .txd, .rx_nibble_clock, .col,
  .crs, .duplex_strap_n, .rx_byte_valid, .rx_frame_end, .rx_odd_nibble, .collision, .carrier,
  .half_duplex, .tx_underrun);
